// ---- hw/odts_consts.svh ----
`ifndef ODTS_CONSTS_SVH
`define ODTS_CONSTS_SVH
// Notes on behaviour
// R1 - DQ, strobe pair and data mask get selectable termination; the termination strobe pair only when its enable bit is set.
// R2 - in self-refresh all termination is off and the pins float, whatever the mode fields hold.
// R3 - the termination control pin is ignored when the nominal field is zero and during self-refresh.
// R4 - termination is enabled when any of nominal, write or parked fields is nonzero, and the chosen field sets the resistance.
// R5 - the state is chosen by fixed priority: read disable, write, nominal, parked.
// R6 - a write together with the control pin high gives write termination, not nominal.
// R7 - a read disables termination and enters driving mode regardless of pin, parked or nominal settings.
// R8 - the written rank keeps write termination for the write period whatever its control pin does.
// R9 - nominal termination turns on whenever the control pin is seen high, unless the nominal field is zero.
// R10 - parked termination applies when its field is nonzero and the pin is low; otherwise the pins float.
// R11 - a read turns termination off from read latency minus X cycles for burst length over two plus X cycles.
// R12 - X is 2 cycles with a one-cycle preamble and 3 cycles with a two-cycle preamble.
// R13 - with the nominal field zero the control pin receiver is powered down.
// R14 - nominal and parked codes mean disable or 240, 120, 80, 60, 48, 40, 34 ohms.
// R15 - the write code means disable, 240, 120 or 80 ohms.
// R16 - the state is re-evaluated on every clock from the current command, pin and fields.

// register byte offsets
`define ODTS_ADDR_MR1      8'h00
`define ODTS_ADDR_MR2      8'h04
`define ODTS_ADDR_MR5      8'h08
`define ODTS_ADDR_TIM      8'h0C
`define ODTS_ADDR_STAT     8'h10
// field positions
`define ODTS_NOM_LSB       8
`define ODTS_STRB_BIT      11
`define ODTS_WR_LSB        9
`define ODTS_PARK_LSB      6
`define ODTS_RL_LSB        0
`define ODTS_BL_LSB        8
`define ODTS_PRE_BIT       12
`define ODTS_WH_LSB        16
`define ODTS_ST_LSB        0
`define ODTS_OHM_LSB       4
`define ODTS_DRV_BIT       12
// reset values
`define ODTS_RST_FIELD     3'h0
`define ODTS_RST_RL        6'h0B
`define ODTS_RST_BL        4'h8
`define ODTS_RST_WH        4'h6
// read window offset per preamble mode
`define ODTS_X_1T          6'h02
`define ODTS_X_2T          6'h03
// resistance per code, in ohms
`define ODTS_OHM_240       8'hF0
`define ODTS_OHM_120       8'h78
`define ODTS_OHM_80        8'h50
`define ODTS_OHM_60        8'h3C
`define ODTS_OHM_48        8'h30
`define ODTS_OHM_40        8'h28
`define ODTS_OHM_34        8'h22
`endif

// ---- hw/odts_pkg.sv ----
package odts_pkg;
    // termination state, one-hot
    typedef enum logic [3:0] {
        ODTS_OFF  = 4'h1,
        ODTS_WR   = 4'h2,
        ODTS_NOM  = 4'h4,
        ODTS_PARK = 4'h8
    } odts_state_e;

    // configuration as seen by the link logic
    typedef struct packed {
        logic [2:0] nom;
        logic       strobe;
        logic [2:0] wr;
        logic [2:0] park;
        logic [5:0] rl;
        logic [3:0] bl;
        logic       pre2;
        logic [3:0] wrHold;
    } odts_cfg_s;

    // status returned to the bus side
    typedef struct packed {
        logic [3:0] state;
        logic [7:0] ohms;
        logic       drive;
    } odts_stat_s;
endpackage

// ---- hw/odts_xfer.sv ----
`timescale 1ns/100ps
// word crossing by toggle handshake; the held word is stable while a toggle is in flight
module odts_xfer #(
    parameter int W = 8
) (
    input  wire logic         srcClk,
    input  wire logic         srcRst,
    input  wire logic [W-1:0] srcData,
    input  wire logic         dstClk,
    input  wire logic         dstRst,
    output logic      [W-1:0] dstData
);
    typedef struct packed {
        logic [W-1:0] hold;
        logic         req;
        logic         ackMeta;
        logic         ackSync;
    } odts_xsrc_s;

    typedef struct packed {
        logic [W-1:0] data;
        logic         reqMeta;
        logic         reqSync;
        logic         ack;
    } odts_xdst_s;

    odts_xsrc_s src_reg;
    odts_xsrc_s src_next;
    odts_xdst_s dst_reg;
    odts_xdst_s dst_next;

    // source: launch a new word only when the previous one was acknowledged
    always_comb begin
        src_next         = src_reg;
        src_next.ackMeta = dst_reg.ack;
        src_next.ackSync = src_reg.ackMeta;
        if ((src_reg.req == src_reg.ackSync) && (srcData != src_reg.hold)) begin
            src_next.hold = srcData;
            src_next.req  = ~src_reg.req;
        end
    end

    always_ff @(posedge srcClk) begin
        if (srcRst) begin
            src_reg <= '0;
        end else begin
            src_reg <= src_next;
        end
    end

    // destination: take the held word once the toggle has settled
    always_comb begin
        dst_next         = dst_reg;
        dst_next.reqMeta = src_reg.req;
        dst_next.reqSync = dst_reg.reqMeta;
        if (dst_reg.reqSync != dst_reg.ack) begin
            dst_next.data = src_reg.hold;
            dst_next.ack  = dst_reg.reqSync;
        end
    end

    always_ff @(posedge dstClk) begin
        if (dstRst) begin
            dst_reg <= '0;
        end else begin
            dst_reg <= dst_next;
        end
    end

    assign dstData = dst_reg.data;
endmodule

// ---- hw/odts_top.sv ----
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`include "odts_consts.svh"
module odts_top (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  wbCyc,
    input  wire logic                  wbStb,
    input  wire logic                  wbWe,
    input  wire logic [7:0]            wbAdr,
    input  wire logic [3:0]            wbSel,
    input  wire logic [31:0]           wbDatI,
    output logic      [31:0]           wbDatO,
    output logic                       wbAck,
    input  wire logic                  linkClk,
    input  wire logic                  termControlPin,
    input  wire logic                  readCmd,
    input  wire logic                  writeCmd,
    input  wire logic                  selfRefresh,
    output odts_pkg::odts_state_e      termState,
    output logic      [2:0]            termCode,
    output logic      [7:0]            termOhms,
    output logic                       driveMode,
    output logic                       dataTermEn,
    output logic                       strobeTermEn,
    output logic                       ctrlPinRxEn
);
    import odts_pkg::*;

    // bus side state
    typedef struct packed {
        logic        ack;
        logic [31:0] datO;
        odts_cfg_s   cfg;
    } odts_bus_s;

    // link side state
    typedef struct packed {
        odts_state_e state;
        logic [2:0]  code;
        logic [7:0]  ohms;
        logic        drive;
        logic        dataEn;
        logic        strobeEn;
        logic        rxEn;
        logic        armed;
        logic [5:0]  dly;
        logic [6:0]  offCnt;
        logic [3:0]  wrCnt;
        logic [6:0]  rdAge;
    } odts_link_s;

    odts_bus_s  bus_reg;
    odts_bus_s  bus_next;
    odts_link_s lnk_reg;
    odts_link_s lnk_next;

    logic        rstLinkMeta;
    logic        rstLink;
    odts_cfg_s   cfgL;
    odts_stat_s  statL;
    odts_stat_s  statB;
    logic [31:0] mr1Word;
    logic [31:0] mr2Word;
    logic [31:0] mr5Word;
    logic [31:0] timWord;
    logic [31:0] statWord;
    logic        busReq;
    logic [5:0]  xVal;
    logic [5:0]  readDly;
    logic [6:0]  offLen;
    logic        offNow;
    logic        wrAct;
    logic        pinSeen;
    logic [6:0]  ageNow;

    // resistance of a nominal or parked code
    function automatic logic [7:0] ohmsOf(input logic [2:0] code);
        case (code)
            3'h1:    ohmsOf = `ODTS_OHM_240;
            3'h2:    ohmsOf = `ODTS_OHM_120;
            3'h3:    ohmsOf = `ODTS_OHM_80;
            3'h4:    ohmsOf = `ODTS_OHM_60;
            3'h5:    ohmsOf = `ODTS_OHM_48;
            3'h6:    ohmsOf = `ODTS_OHM_40;
            3'h7:    ohmsOf = `ODTS_OHM_34;
            default: ohmsOf = 8'h00;
        endcase
    endfunction

    // write codes above 3 (the 80 ohm code) are reserved and treated as disabled
    function automatic logic [7:0] wrOhmsOf(input logic [2:0] code);
        wrOhmsOf = (code <= 3'h3) ? ohmsOf(code) : 8'h00; // [R15]
    endfunction

    // byte-lane merge for a bus write
    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] dat,
                                              input logic [3:0] sel);
        laneMerge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                laneMerge[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
    endfunction

    // register images, reserved bits read as zero
    assign mr1Word  = (32'(bus_reg.cfg.nom) << `ODTS_NOM_LSB) | (32'(bus_reg.cfg.strobe) << `ODTS_STRB_BIT);
    assign mr2Word  = 32'(bus_reg.cfg.wr) << `ODTS_WR_LSB;
    assign mr5Word  = 32'(bus_reg.cfg.park) << `ODTS_PARK_LSB;
    assign timWord  = (32'(bus_reg.cfg.rl) << `ODTS_RL_LSB) | (32'(bus_reg.cfg.bl) << `ODTS_BL_LSB)
                    | (32'(bus_reg.cfg.pre2) << `ODTS_PRE_BIT) | (32'(bus_reg.cfg.wrHold) << `ODTS_WH_LSB);
    assign statWord = (32'(statB.state) << `ODTS_ST_LSB) | (32'(statB.ohms) << `ODTS_OHM_LSB)
                    | (32'(statB.drive) << `ODTS_DRV_BIT);
    assign busReq   = wbCyc && wbStb;

    // bus slave: ack one cycle after the request, writes commit on the ack edge
    always_comb begin
        logic [31:0] merged;
        merged        = 32'h0000_0000;
        bus_next      = bus_reg;
        bus_next.ack  = busReq && !bus_reg.ack;
        bus_next.datO = 32'h0000_0000;
        if (busReq && !bus_reg.ack && !wbWe) begin
            case (wbAdr)
                `ODTS_ADDR_MR1:  bus_next.datO = mr1Word;
                `ODTS_ADDR_MR2:  bus_next.datO = mr2Word;
                `ODTS_ADDR_MR5:  bus_next.datO = mr5Word;
                `ODTS_ADDR_TIM:  bus_next.datO = timWord;
                `ODTS_ADDR_STAT: bus_next.datO = statWord;
                default:         bus_next.datO = 32'h0000_0000;
            endcase
        end
        if (busReq && bus_reg.ack && wbWe) begin
            case (wbAdr)
                `ODTS_ADDR_MR1: begin
                    merged              = laneMerge(mr1Word, wbDatI, wbSel);
                    bus_next.cfg.nom    = merged[`ODTS_NOM_LSB +: 3];
                    bus_next.cfg.strobe = merged[`ODTS_STRB_BIT];
                end
                `ODTS_ADDR_MR2: begin
                    merged          = laneMerge(mr2Word, wbDatI, wbSel);
                    bus_next.cfg.wr = merged[`ODTS_WR_LSB +: 3];
                end
                `ODTS_ADDR_MR5: begin
                    merged            = laneMerge(mr5Word, wbDatI, wbSel);
                    bus_next.cfg.park = merged[`ODTS_PARK_LSB +: 3];
                end
                `ODTS_ADDR_TIM: begin
                    merged              = laneMerge(timWord, wbDatI, wbSel);
                    bus_next.cfg.rl     = merged[`ODTS_RL_LSB +: 6];
                    bus_next.cfg.bl     = merged[`ODTS_BL_LSB +: 4];
                    bus_next.cfg.pre2   = merged[`ODTS_PRE_BIT];
                    bus_next.cfg.wrHold = merged[`ODTS_WH_LSB +: 4];
                end
                default: merged = 32'h0000_0000; // status and unmapped ignore writes
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_reg             <= '0;
            bus_reg.cfg.nom     <= `ODTS_RST_FIELD;
            bus_reg.cfg.wr      <= `ODTS_RST_FIELD;
            bus_reg.cfg.park    <= `ODTS_RST_FIELD;
            bus_reg.cfg.rl      <= `ODTS_RST_RL;
            bus_reg.cfg.bl      <= `ODTS_RST_BL;
            bus_reg.cfg.wrHold  <= `ODTS_RST_WH;
        end else begin
            bus_reg <= bus_next;
        end
    end

    assign wbAck  = bus_reg.ack;
    assign wbDatO = bus_reg.datO;

    // reset carried into the link domain; first stage feeds only the second
    always_ff @(posedge linkClk) begin
        rstLinkMeta <= rst;
        rstLink     <= rstLinkMeta;
    end

    // configuration to the link, status back; fields change rarely so a handshake is cheap
    odts_xfer #(.W($bits(odts_cfg_s))) cfgXfer (
        .srcClk  (clk),
        .srcRst  (rst),
        .srcData (bus_reg.cfg),
        .dstClk  (linkClk),
        .dstRst  (rstLink),
        .dstData (cfgL)
    );

    assign statL = '{state: lnk_reg.state, ohms: lnk_reg.ohms, drive: lnk_reg.drive};

    odts_xfer #(.W($bits(odts_stat_s))) statXfer (
        .srcClk  (linkClk),
        .srcRst  (rstLink),
        .srcData (statL),
        .dstClk  (clk),
        .dstRst  (rst),
        .dstData (statB)
    );

    // read window timing
    assign xVal    = cfgL.pre2 ? `ODTS_X_2T : `ODTS_X_1T;                 // [R12]
    assign readDly = (cfgL.rl > xVal) ? (cfgL.rl - xVal) : 6'h00;         // [R11]
    assign offLen  = 7'(cfgL.bl >> 1) + 7'(xVal);                         // [R11]
    assign ageNow  = readCmd ? 7'h00 : lnk_reg.rdAge;

    // termination state chosen afresh every link clock [R16]
    always_comb begin
        logic [7:0] ohmsSel;
        ohmsSel           = 8'h00;
        lnk_next          = lnk_reg;
        offNow            = (lnk_reg.offCnt != 7'h00) || (lnk_reg.armed && (lnk_reg.dly == 6'h00));
        if (lnk_reg.offCnt != 7'h00) begin
            lnk_next.offCnt = lnk_reg.offCnt - 7'h01;
        end
        if (lnk_reg.armed && (lnk_reg.dly == 6'h00)) begin
            lnk_next.armed  = 1'b0;
            lnk_next.offCnt = offLen - 7'h01;                             // [R11]
        end else if (lnk_reg.armed) begin
            lnk_next.dly = lnk_reg.dly - 6'h01;
        end
        // a newer read restarts the delay to its own window
        if (readCmd) begin
            if (readDly == 6'h00) begin
                offNow          = 1'b1;
                lnk_next.armed  = 1'b0;
                lnk_next.offCnt = offLen - 7'h01;
            end else begin
                lnk_next.armed = 1'b1;
                lnk_next.dly   = readDly - 6'h01;
            end
        end
        lnk_next.rdAge = (ageNow == 7'h7F) ? ageNow : ageNow + 7'h01;
        // write period held whatever the pin does [R8]
        wrAct = writeCmd || (lnk_reg.wrCnt != 4'h0);
        if (lnk_reg.wrCnt != 4'h0) begin
            lnk_next.wrCnt = lnk_reg.wrCnt - 4'h1;
        end
        if (writeCmd) begin
            lnk_next.wrCnt = (cfgL.wrHold == 4'h0) ? 4'h0 : cfgL.wrHold - 4'h1;
        end
        // pin is only looked at with nominal enabled and outside self-refresh [R3]
        pinSeen       = termControlPin && (cfgL.nom != 3'h0) && !selfRefresh;
        lnk_next.rxEn = (cfgL.nom != 3'h0) && !selfRefresh;               // [R13]
        lnk_next.state = ODTS_OFF;
        lnk_next.code  = 3'h0;
        lnk_next.drive = 1'b0;
        // fixed priority: self-refresh, read, write, nominal, parked [R5]
        if (selfRefresh) begin
            lnk_next.state = ODTS_OFF;                                    // [R2]
        end else if (offNow) begin
            lnk_next.drive = 1'b1;                                        // [R7]
        end else if (wrAct && (wrOhmsOf(cfgL.wr) != 8'h00)) begin
            lnk_next.state = ODTS_WR;                                     // [R6] [R8]
            lnk_next.code  = cfgL.wr;
            ohmsSel        = wrOhmsOf(cfgL.wr);                           // [R15]
        end else if (pinSeen) begin
            lnk_next.state = ODTS_NOM;                                    // [R9]
            lnk_next.code  = cfgL.nom;
            ohmsSel        = ohmsOf(cfgL.nom);                            // [R14]
        end else if (cfgL.park != 3'h0) begin
            lnk_next.state = ODTS_PARK;                                   // [R10]
            lnk_next.code  = cfgL.park;
            ohmsSel        = ohmsOf(cfgL.park);                           // [R14]
        end
        // all-zero fields leave the write, nominal and parked branches off, so termination is disabled [R4]
        lnk_next.ohms     = ohmsSel;
        lnk_next.dataEn   = (lnk_next.state != ODTS_OFF);                 // [R1]
        lnk_next.strobeEn = (lnk_next.state != ODTS_OFF) && cfgL.strobe;  // [R1]
    end

    always_ff @(posedge linkClk) begin
        if (rstLink) begin
            lnk_reg       <= '0;
            lnk_reg.state <= ODTS_OFF;
        end else begin
            lnk_reg <= lnk_next;
        end
    end

    assign termState    = lnk_reg.state;
    assign termCode     = lnk_reg.code;
    assign termOhms     = lnk_reg.ohms;
    assign driveMode    = lnk_reg.drive;
    assign dataTermEn   = lnk_reg.dataEn;
    assign strobeTermEn = lnk_reg.strobeEn;
    assign ctrlPinRxEn  = lnk_reg.rxEn;

    // checks on the link side, plus one on the bus ack
    a_selfref_hiz: assert property (@(posedge linkClk) disable iff (rstLink) // [R2]
        selfRefresh |=> (termState == ODTS_OFF) && !driveMode && (termOhms == 8'h00) && !dataTermEn)
        else $error("termination not off in self-refresh");

    a_read_disable: assert property (@(posedge linkClk) disable iff (rstLink) // [R7]
        (offNow && !selfRefresh) |=> (termState == ODTS_OFF) && driveMode && !strobeTermEn)
        else $error("read window did not disable termination");

    a_read_delay: assert property (@(posedge linkClk) disable iff (rstLink) // [R11]
        (offNow && !$past(offNow)) |-> (ageNow == 7'(readDly)))
        else $error("read disable started at wrong delay");

    a_offset_value: assert property (@(posedge linkClk) disable iff (rstLink) // [R12]
        xVal == (cfgL.pre2 ? 6'h03 : 6'h02))
        else $error("read window offset wrong for preamble mode");

    a_write_wins: assert property (@(posedge linkClk) disable iff (rstLink) // [R6]
        (writeCmd && termControlPin && !offNow && !selfRefresh && (cfgL.wr inside {3'h1, 3'h2, 3'h3}))
        |=> (termState == ODTS_WR) && (termCode == $past(cfgL.wr)))
        else $error("write with pin high did not give write termination");

    a_write_hold: assert property (@(posedge linkClk) disable iff (rstLink) // [R8]
        (writeCmd && (cfgL.wrHold >= 4'h2) && (cfgL.wr inside {3'h1, 3'h2, 3'h3})) ##1
        (!offNow && !selfRefresh && !readCmd && $stable(cfgL)) |=> (termState == ODTS_WR))
        else $error("write termination dropped inside write period");

    a_pin_ignored: assert property (@(posedge linkClk) disable iff (rstLink) // [R3]
        ((cfgL.nom == 3'h0) && (cfgL.park != 3'h0) && !offNow && !wrAct && !selfRefresh)
        |=> (termState == ODTS_PARK))
        else $error("pin not ignored with nominal disabled");

    a_nom_on: assert property (@(posedge linkClk) disable iff (rstLink) // [R9]
        (termControlPin && (cfgL.nom != 3'h0) && !offNow && !wrAct && !selfRefresh)
        |=> (termState == ODTS_NOM) && (termOhms == ohmsOf($past(cfgL.nom))))
        else $error("nominal termination not applied");

    a_park_hiz: assert property (@(posedge linkClk) disable iff (rstLink) // [R10]
        (!termControlPin && (cfgL.park == 3'h0) && !offNow && !wrAct)
        |=> (termState == ODTS_OFF) && !driveMode)
        else $error("pins not floating with parked disabled");

    a_rx_power: assert property (@(posedge linkClk) disable iff (rstLink) // [R13]
        (cfgL.nom == 3'h0) |=> !ctrlPinRxEn)
        else $error("pin receiver powered with nominal disabled");

    a_wr_code: assert property (@(posedge linkClk) disable iff (rstLink) // [R15]
        (termState == ODTS_WR) |-> (termCode inside {3'h1, 3'h2, 3'h3}) && (termOhms >= 8'h50))
        else $error("write termination with reserved code");

    a_strobe_gate: assert property (@(posedge linkClk) disable iff (rstLink) // [R1]
        strobeTermEn |-> dataTermEn && $past(cfgL.strobe))
        else $error("strobe pair terminated without its enable");

    a_bus_ack: assert property (@(posedge clk) disable iff (rst)
        (busReq && !wbAck) |=> wbAck ##1 !wbAck)
        else $error("bus ack not a single cycle after request");

    c_read_window: cover property (@(posedge linkClk) disable iff (rstLink)
        readCmd ##[1:40] driveMode);
    c_write_nom: cover property (@(posedge linkClk) disable iff (rstLink)
        (termState == ODTS_NOM) ##1 (termState == ODTS_WR));
    c_park: cover property (@(posedge linkClk) disable iff (rstLink)
        (termState == ODTS_PARK) ##1 (termState == ODTS_NOM));
    c_selfref: cover property (@(posedge linkClk) disable iff (rstLink)
        (termState == ODTS_PARK) ##1 selfRefresh ##1 (termState == ODTS_OFF));
endmodule

// ---- test/odts_ctrl_model.sv ----
`timescale 1ns/100ps
// controller side: pin, commands and self-refresh, all launched just after a link edge
module odts_ctrl_model (
    input  wire logic linkClk,
    output logic      termControlPin,
    output logic      readCmd,
    output logic      writeCmd,
    output logic      selfRefresh
);
    // idle levels at time zero
    initial begin
        termControlPin = 1'b0;
        readCmd = 1'b0;
        writeCmd = 1'b0;
        selfRefresh = 1'b0;
    end
    // level changes take effect from the next link edge
    task automatic setPin(input logic v);
        @(posedge linkClk);
        termControlPin <= v;
    endtask
    task automatic setSr(input logic v);
        @(posedge linkClk);
        selfRefresh <= v;
    endtask
    // one-cycle command; returns at the edge that samples it
    task automatic pulse(input logic rd);
        @(posedge linkClk);
        readCmd <= rd;
        writeCmd <= !rd;
        @(posedge linkClk);
        readCmd <= 1'b0;
        writeCmd <= 1'b0;
    endtask
endmodule

// ---- test/odts_top_tb.sv ----
`timescale 1ns/100ps
`include "odts_consts.svh"
module odts_top_tb;
    import odts_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              linkClk = 1'b0;
    logic              wbCyc = 1'b0;
    logic              wbStb = 1'b0;
    logic              wbWe = 1'b0;
    logic        [7:0] wbAdr = 8'h00;
    logic        [3:0] wbSel = 4'hF;
    logic       [31:0] wbDatI = 32'h0;
    logic       [31:0] wbDatO;
    logic       [31:0] q;
    logic              wbAck;
    logic              termControlPin;
    logic              readCmd;
    logic              writeCmd;
    logic              selfRefresh;
    logic              driveMode;
    logic              dataTermEn;
    logic              strobeTermEn;
    logic              ctrlPinRxEn;
    odts_state_e       termState;
    logic        [2:0] termCode;
    logic        [7:0] termOhms;
    logic        [7:0] ohms [8] = '{8'h00, 8'hF0, 8'h78, 8'h50, 8'h3C, 8'h30, 8'h28, 8'h22};
    int                n_fail = 0;
    int                compares = 0;
    int                n;
    odts_top dut (.clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatI, .wbDatO, .wbAck, .linkClk,
        .termControlPin, .readCmd, .writeCmd, .selfRefresh, .termState, .termCode, .termOhms, .driveMode,
        .dataTermEn, .strobeTermEn, .ctrlPinRxEn);
    odts_ctrl_model ctrl (.linkClk, .termControlPin, .readCmd, .writeCmd, .selfRefresh);
    // 25 MHz bus clock; link clock offset by 3.3 ns so no edge of the two ever coincides
    always #20 clk = ~clk;
    initial begin
        #3.3;
        forever #6 linkClk = ~linkClk;
    end
    task automatic close_out;
        if (n_fail == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // classic cycle: hold everything until ack is sampled, then release
    task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        int k;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatI <= d;
        wbSel <= s;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wbAck !== 1'b1 && k < 50);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        if (k >= 50) chk("ack", 1, 0);
    endtask
    // config crosses to the link domain with a few cycles of lag
    task automatic cfg(input logic [7:0] a, input logic [31:0] d);
        wbx(1'b1, a, d);
        repeat (20) @(posedge clk);
    endtask
    task automatic lnk(input int k);
        repeat (k) @(posedge linkClk);
        #1;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #400000;
        n_fail++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        lnk(10);
        chk("state", ODTS_OFF, termState);
        wbx(1'b0, `ODTS_ADDR_TIM, 0);
        chk("tim", 32'h0006080B, q);
        // only the low lane lands, so just the read latency changes
        wbx(1'b1, `ODTS_ADDR_TIM, 32'hFFFFFF0D, 4'h1);
        wbx(1'b0, `ODTS_ADDR_TIM, 0);
        chk("timlane", 32'h0006080D, q);
        wbx(1'b0, 8'h14, 0);
        chk("unmapped", 0, q);
        cfg(`ODTS_ADDR_MR5, 32'h000000C0);
        lnk(3);
        chk("park", {ODTS_PARK, 3'h3, ohms[3], 2'b10}, {termState, termCode, termOhms, dataTermEn, strobeTermEn});
        ctrl.setPin(1'b1);
        // every nonzero nominal code with the pin high and the strobe pair enabled
        for (int c = 1; c < 8; c++) begin
            cfg(`ODTS_ADDR_MR1, 32'h00000800 | (c << 8));
            lnk(3);
            chk("nom", {ODTS_NOM, ohms[c], 2'b11}, {termState, termOhms, strobeTermEn, ctrlPinRxEn});
        end
        wbx(1'b0, `ODTS_ADDR_STAT, 0);
        chk("stat", ODTS_NOM, q[3:0]);
        cfg(`ODTS_ADDR_MR2, 32'h00000400);
        // write with the pin high then low: write state for six cycles either way
        for (int p = 1; p >= 0; p--) begin
            ctrl.setPin(p[0]);
            lnk(2);
            ctrl.pulse(1'b0);
            #1;
            chk("wr", {ODTS_WR, 3'h2, ohms[2]}, {termState, termCode, termOhms});
            lnk(5);
            chk("wrhold", ODTS_WR, termState);
            lnk(1);
            chk("wrend", p ? ODTS_NOM : ODTS_PARK, termState);
        end
        cfg(`ODTS_ADDR_MR2, 32'h00000A00);
        ctrl.pulse(1'b0);
        lnk(1);
        chk("wrrsv", ODTS_PARK, termState);
        ctrl.setPin(1'b1);
        // read window per preamble mode: start RL-X, length BL/2+X
        for (int p = 0; p < 2; p++) begin
            cfg(`ODTS_ADDR_TIM, 32'h0006080B | (p << 12));
            ctrl.pulse(1'b1);
            n = 0;
            do begin
                lnk(1);
                n++;
            end while (driveMode !== 1'b1 && n < 40);
            chk("rdstart", 9 - p, n);
            chk("rdoff", {ODTS_OFF, 1'b0}, {termState, dataTermEn});
            n = 1;
            while (driveMode === 1'b1 && n < 40) begin
                lnk(1);
                n++;
            end
            chk("rdlen", 6 + p, n - 1);
        end
        ctrl.setSr(1'b1);
        lnk(3);
        chk("sref", {ODTS_OFF, 2'b00}, {termState, dataTermEn, ctrlPinRxEn});
        ctrl.setSr(1'b0);
        cfg(`ODTS_ADDR_MR1, 0);
        cfg(`ODTS_ADDR_MR5, 0);
        lnk(3);
        chk("allzero", {ODTS_OFF, 2'b00}, {termState, dataTermEn, ctrlPinRxEn});
        close_out();
    end
endmodule
